// ==== design/rss_pkg.sv ====
package rss_pkg;

    // Clock rate and unit scales.
    localparam int  CLK_PERIOD_NS = 10;
    localparam real NS_PER_MS     = 1.0e6;
    localparam real NS_PER_US     = 1.0e3;

    // Least durations of each sequence, as printed.
    localparam real DESTR_SELFTEST_MIN_MS = 6.2;
    localparam real DESTR_PLAIN_MIN_US    = 110.0;
    localparam real EXT_LONG_MIN_MS       = 6.2;
    localparam real FUNC_LONG_MIN_US      = 110.0;
    localparam real FUNC_SHORT_MIN_US     = 7.0;

    // Boot loader run times, header at first and at last location.
    localparam real BOOT_FIRST_TYP_US = 200.0;
    localparam real BOOT_LAST_MAX_US  = 320.0;

    // Cycle counts: least times round up, the longest time rounds down.
    localparam int DESTR_SELFTEST_CYC =
        int'($ceil(DESTR_SELFTEST_MIN_MS * NS_PER_MS / CLK_PERIOD_NS));
    localparam int DESTR_PLAIN_CYC =
        int'($ceil(DESTR_PLAIN_MIN_US * NS_PER_US / CLK_PERIOD_NS));
    localparam int EXT_LONG_CYC =
        int'($ceil(EXT_LONG_MIN_MS * NS_PER_MS / CLK_PERIOD_NS));
    localparam int FUNC_LONG_CYC =
        int'($ceil(FUNC_LONG_MIN_US * NS_PER_US / CLK_PERIOD_NS));
    localparam int FUNC_SHORT_CYC =
        int'($ceil(FUNC_SHORT_MIN_US * NS_PER_US / CLK_PERIOD_NS));
    localparam int BOOT_FIRST_CYC =
        int'($ceil(BOOT_FIRST_TYP_US * NS_PER_US / CLK_PERIOD_NS));
    localparam int BOOT_LAST_CYC =
        int'($floor(BOOT_LAST_MAX_US * NS_PER_US / CLK_PERIOD_NS));

    // Width of the duration counter; holds the longest count.
    localparam int CNT_W = 20;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_ASSERT,
        ST_RESET_PHASE_THREE,
        ST_BOOT,
        ST_RUN
    } rss_state_t;

    // Cause of the running sequence.
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_DESTR_SELFTEST,
        SRC_DESTR_PLAIN,
        SRC_EXT_LONG,
        SRC_FUNC_LONG,
        SRC_FUNC_SHORT
    } rss_src_t;

    // Complete sequencer state.
    typedef struct packed {
        rss_state_t st;
        rss_src_t   src;
        logic       pin_oe;
        logic       core_rst_n;
        logic       run;
        logic       boot;
    } rss_seq_t;

    // Values after reset.
    localparam rss_seq_t SEQ_RESET = '{
        st:         ST_POWERUP,
        src:        SRC_NONE,
        pin_oe:     1'b1,
        core_rst_n: 1'b0,
        run:        1'b0,
        boot:       1'b0
    };
    localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;

endpackage

// ==== design/rss_timer_if.sv ====
`timescale 1ns/1ns
// Load and expiry of the duration counter.
interface rss_timer_if;
    logic                     load;
    logic [rss_pkg::CNT_W-1:0] load_val;
    logic                     done;

    modport ctl (output load, output load_val, input done);
    modport tmr (input load, input load_val, output done);
endinterface

// ==== design/rss_timer.sv ====
`timescale 1ns/1ns
// Down counter that measures one phase of the sequence.
module rss_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control from the sequencer
    rss_timer_if.tmr tif
);
    import rss_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } rss_tmr_t;

    rss_tmr_t cur_ff;
    rss_tmr_t nxt_tmr;

    // A load wins over counting, so a restart always gets the full time.
    always_comb begin
        nxt_tmr = cur_ff;
        if (tif.load) begin
            nxt_tmr.cnt = tif.load_val;
        end else if (cur_ff.cnt != CNT_RESET) begin
            nxt_tmr.cnt = cur_ff.cnt - 20'h00001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '{cnt: CNT_RESET};
        end else begin
            cur_ff <= nxt_tmr;
        end
    end

    // Expired once the count reaches zero and no new load is pending.
    assign tif.done = (cur_ff.cnt == CNT_RESET) && !tif.load;

endmodule

// ==== design/rss_sequencer.sv ====
`timescale 1ns/1ns
// Reset sequencer: times each reset sequence, owns the reset pin and
// releases the core into the boot loader and then into normal run mode.
//
// Flow of one sequence:
//   assert : the phase counter runs the least time of the cause in force,
//            and the pin is pulled low unless the cause may not drive it.
//   reset_phase_three : the pin is let go; the sequence waits here while anything
//            outside still holds the pin low, which lengthens the reset.
//   boot   : the core leaves reset and the boot loader time is counted.
//   run    : normal run mode, the point at which the application starts.
//
// Causes, strongest first:
//   destructive (power-up included), with or without self test;
//   external, seen as a low pin that this end is not pulling;
//   functional, long or short, pin drive chosen per request.
//
// Any cause but an external low in phase three restarts the sequence from the top with its full time, so a
// request is never merged into a shorter sequence already running. The
// trade-off is that a cause held high keeps the core in reset forever;
// the callers are expected to pulse or drop their requests.
//
// Limitation: while this end pulls the pin, an outside hold cannot be
// seen at all, because the pin reads low in either case. Such a hold
// only shows once the pin is let go in phase three, where it extends
// the reset instead of restarting it.
module rss_sequencer #(
    parameter int DESTR_SELFTEST_CYC_P = rss_pkg::DESTR_SELFTEST_CYC,
    parameter int DESTR_PLAIN_CYC_P    = rss_pkg::DESTR_PLAIN_CYC,
    parameter int EXT_LONG_CYC_P       = rss_pkg::EXT_LONG_CYC,
    parameter int FUNC_LONG_CYC_P      = rss_pkg::FUNC_LONG_CYC,
    parameter int BOOT_FIRST_CYC_P     = rss_pkg::BOOT_FIRST_CYC,
    parameter int BOOT_LAST_CYC_P      = rss_pkg::BOOT_LAST_CYC
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,

    // Reset causes
    input  wire logic        destr_req,
    input  wire logic        selftest_en,
    input  wire logic        func_req,
    input  wire logic        func_long,
    input  wire logic        functional_reset_pin_enable,

    // Boot header location
    input  wire logic        boot_hdr_last,

    // Two-way reset pin
    input  wire logic        rst_pin_in,
    output logic             rst_pin_out,
    output logic             rst_pin_oe,

    // Status
    output logic             core_rst_n,
    output logic             boot_assist_loader,
    output logic             normal_run_mode,
    output rss_pkg::rss_src_t seq_src
);
    import rss_pkg::*;

    // Load values, cut to the counter width.
    localparam logic [CNT_W-1:0] LD_DESTR_SELFTEST =
        CNT_W'(DESTR_SELFTEST_CYC_P);
    localparam logic [CNT_W-1:0] LD_DESTR_PLAIN =
        CNT_W'(DESTR_PLAIN_CYC_P);
    localparam logic [CNT_W-1:0] LD_EXT_LONG =
        CNT_W'(EXT_LONG_CYC_P);
    localparam logic [CNT_W-1:0] LD_FUNC_LONG =
        CNT_W'(FUNC_LONG_CYC_P);
    localparam logic [CNT_W-1:0] LD_FUNC_SHORT =
        CNT_W'(FUNC_SHORT_CYC);
    localparam logic [CNT_W-1:0] LD_BOOT_FIRST =
        CNT_W'(BOOT_FIRST_CYC_P);
    localparam logic [CNT_W-1:0] LD_BOOT_LAST =
        CNT_W'(BOOT_LAST_CYC_P);

    rss_seq_t    cur_ff;
    rss_seq_t    nxt_seq;
    logic        ext_low;
    logic        start;
    rss_src_t    start_src;
    logic        start_drive;
    logic [CNT_W-1:0] start_len;

    rss_timer_if tif ();

    // Phase duration counter. It is shared by the assert and boot
    // phases, which never overlap, so one counter of the widest length
    // is enough; the price is that both phases reload it on entry.
    rss_timer u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tif      (tif)
    );

    // The pin is low from outside only when this end is not pulling it.
    // Inputs are synchronous, so a released pin reads high next cycle
    // when the pull-up is strong enough; a weak pull-up reads as an
    // external hold.
    assign ext_low = !rst_pin_in && !cur_ff.pin_oe;

    // Pick the sequence to start, strongest cause first.
    always_comb begin
        start       = 1'b0;
        start_src   = SRC_NONE;
        start_drive = 1'b1;
        start_len   = LD_FUNC_SHORT;
        if (cur_ff.st == ST_POWERUP || destr_req) begin
            start = 1'b1;
            if (selftest_en) begin
                start_src = SRC_DESTR_SELFTEST;
                start_len = LD_DESTR_SELFTEST;
            end else begin
                start_src = SRC_DESTR_PLAIN;
                start_len = LD_DESTR_PLAIN;
            end
        end else if (ext_low && cur_ff.st != ST_RESET_PHASE_THREE) begin
            // Held low again while running: restart the long sequence.
            start     = 1'b1;
            start_src = SRC_EXT_LONG;
            start_len = LD_EXT_LONG;
        end else if (func_req) begin
            start       = 1'b1;
            start_drive = functional_reset_pin_enable;
            if (func_long) begin
                start_src = SRC_FUNC_LONG;
                start_len = LD_FUNC_LONG;
            end else begin
                start_src = SRC_FUNC_SHORT;
                start_len = LD_FUNC_SHORT;
            end
        end
    end

    // Next state. A new cause restarts from the top in any state but an external
    // low in phase three, so a reset that lands inside a sequence is never lost.
    always_comb begin
        nxt_seq      = cur_ff;
        tif.load     = 1'b0;
        tif.load_val = start_len;
        if (start) begin
            nxt_seq.st     = ST_ASSERT;
            nxt_seq.src    = start_src;
            nxt_seq.pin_oe = start_drive;
            tif.load       = 1'b1;
        end else begin
            unique case (cur_ff.st)
                ST_POWERUP: begin
                    nxt_seq.st = ST_POWERUP;
                end
                ST_ASSERT: begin
                    // Stop pulling the pin once the least time is over.
                    if (tif.done) begin
                        nxt_seq.st     = ST_RESET_PHASE_THREE;
                        nxt_seq.pin_oe = 1'b0;
                    end
                end
                ST_RESET_PHASE_THREE: begin
                    // Stay here while the outside keeps the pin low.
                    if (rst_pin_in) begin
                        nxt_seq.st   = ST_BOOT;
                        tif.load     = 1'b1;
                        tif.load_val = boot_hdr_last ? LD_BOOT_LAST
                                                     : LD_BOOT_FIRST;
                    end
                end
                ST_BOOT: begin
                    if (tif.done) begin
                        nxt_seq.st = ST_RUN;
                    end
                end
                ST_RUN: begin
                    nxt_seq.st = ST_RUN;
                end
            endcase
        end
        // Status follows the next state so it leaves a flip-flop.
        nxt_seq.core_rst_n = (nxt_seq.st == ST_BOOT) ||
                             (nxt_seq.st == ST_RUN);
        nxt_seq.boot       = (nxt_seq.st == ST_BOOT);
        nxt_seq.run        = (nxt_seq.st == ST_RUN);
    end

    // State register; under reset the pin is pulled low, so the rest of
    // the system is held in reset while this block itself is held.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= SEQ_RESET;
        end else begin
            cur_ff <= nxt_seq;
        end
    end

    // Pin drive: low only, released by dropping the enable. The level
    // is tied low so no path can ever push the pin high; the high level
    // comes only from the pull-up outside.
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe  = cur_ff.pin_oe;

    // Status outputs.
    assign core_rst_n         = cur_ff.core_rst_n;
    assign boot_assist_loader = cur_ff.boot;
    assign normal_run_mode    = cur_ff.run;
    assign seq_src            = cur_ff.src;

endmodule

// ==== test/rss_sequencer_asserts.sv ====
`timescale 1ns/1ns
// Port-level timing checks for the reset sequencer.
module rss_sequencer_asserts
    import rss_pkg::*;
#(
    parameter int DESTR_SELFTEST_CYC_P = 1,
    parameter int DESTR_PLAIN_CYC_P    = 1,
    parameter int EXT_LONG_CYC_P       = 1,
    parameter int FUNC_LONG_CYC_P      = 1,
    parameter int BOOT_FIRST_CYC_P     = 1,
    parameter int BOOT_LAST_CYC_P      = 1
) (
    // Clock, reset and causes
    input wire logic              core_clk,
    input wire logic              rst_n,
    input wire logic              destr_req,
    input wire logic              selftest_en,
    input wire logic              func_req,
    input wire logic              func_long,
    input wire logic              functional_reset_pin_enable,
    // Pin and status
    input wire logic              rst_pin_in,
    input wire logic              rst_pin_out,
    input wire logic              rst_pin_oe,
    input wire logic              core_rst_n,
    input wire logic              boot_assist_loader,
    input wire logic              normal_run_mode,
    input wire rss_pkg::rss_src_t seq_src
);
    logic [CNT_W-1:0] oe_cnt_ff;
    logic [CNT_W-1:0] boot_cnt_ff;
    int               oe_min;

    // Lengths of the pin pull and of the boot phase, in cycles.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_cnt_ff   <= '0;
            boot_cnt_ff <= '0;
        end else begin
            oe_cnt_ff   <= rst_pin_oe ? oe_cnt_ff + 1'b1 : '0;
            boot_cnt_ff <= boot_assist_loader ? boot_cnt_ff + 1'b1 : '0;
        end
    end

    // Least pull length for the cause in force.
    always_comb begin
        case (seq_src)
            SRC_DESTR_SELFTEST: oe_min = DESTR_SELFTEST_CYC_P;
            SRC_DESTR_PLAIN:    oe_min = DESTR_PLAIN_CYC_P;
            SRC_EXT_LONG:       oe_min = EXT_LONG_CYC_P;
            SRC_FUNC_LONG:      oe_min = FUNC_LONG_CYC_P;
            SRC_FUNC_SHORT:     oe_min = FUNC_SHORT_CYC;
            default:            oe_min = 0;
        endcase
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    pin_no_high_a: assert property (rst_pin_out == 1'b0)
        else $error("reset pin driven high");
    destr_start_a: assert property (destr_req |=> rst_pin_oe && !core_rst_n
        && seq_src == ($past(selftest_en) ? SRC_DESTR_SELFTEST
        : SRC_DESTR_PLAIN)) else $error("destructive start wrong");
    func_start_a: assert property (func_req && !destr_req && rst_pin_in
        && seq_src != SRC_NONE |=> !core_rst_n
        && rst_pin_oe == $past(functional_reset_pin_enable)
        && seq_src == ($past(func_long) ? SRC_FUNC_LONG : SRC_FUNC_SHORT))
        else $error("functional start wrong");
    ext_start_a: assert property (!rst_pin_in && !rst_pin_oe && core_rst_n
        && !destr_req |=> seq_src == SRC_EXT_LONG && rst_pin_oe)
        else $error("external start wrong");
    pin_low_hold_a: assert property (!rst_pin_in
        |=> !core_rst_n && !normal_run_mode) else $error("pin low ignored");
    oe_length_a: assert property ($fell(rst_pin_oe) && !$past(func_req)
        |-> int'(oe_cnt_ff) > oe_min) else $error("reset too short");
    boot_length_a: assert property ($fell(boot_assist_loader)
        && normal_run_mode |-> int'(boot_cnt_ff) >= BOOT_FIRST_CYC_P
        && int'(boot_cnt_ff) <= BOOT_LAST_CYC_P + 1)
        else $error("boot length wrong");
    core_release_a: assert property ($rose(core_rst_n) |-> $past(rst_pin_in)
        && boot_assist_loader) else $error("core released early");
    run_entry_a: assert property ($rose(normal_run_mode)
        |-> $past(boot_assist_loader) && core_rst_n)
        else $error("run entered without boot");
endmodule

bind rss_sequencer rss_sequencer_asserts #(
    .DESTR_SELFTEST_CYC_P(DESTR_SELFTEST_CYC_P),
    .DESTR_PLAIN_CYC_P(DESTR_PLAIN_CYC_P), .EXT_LONG_CYC_P(EXT_LONG_CYC_P),
    .FUNC_LONG_CYC_P(FUNC_LONG_CYC_P), .BOOT_FIRST_CYC_P(BOOT_FIRST_CYC_P),
    .BOOT_LAST_CYC_P(BOOT_LAST_CYC_P)) i_rss_sequencer_asserts (
    .core_clk, .rst_n, .destr_req, .selftest_en, .func_req, .func_long,
    .functional_reset_pin_enable, .rst_pin_in, .rst_pin_out, .rst_pin_oe,
    .core_rst_n, .boot_assist_loader, .normal_run_mode, .seq_src);

// ==== test/rss_ext_gen.sv ====
`timescale 1ns/1ns
// External reset generator with a pull-up on the shared reset pin.
module rss_ext_gen (
    // Device side of the pin
    input  wire logic rst_pin_out,
    input  wire logic rst_pin_oe,
    // Bench command
    input  wire logic hold_low,
    // Resolved pin level
    output logic      rst_pin_in
);
    // Either party may pull low; a wrong drive high by the device shows up.
    assign rst_pin_in = hold_low ? 1'b0 : (rst_pin_oe ? rst_pin_out : 1'b1);
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
// Directed bench for the reset sequencer.
module tb_top;
    import rss_pkg::*;
    // Short counts keep the run brief.
    localparam int DST = 40, DPL = 20, EXL = 40, FNL = 20;
    logic     core_clk = 1'b0, rst_n = 1'b0, destr_req = 1'b0;
    logic     selftest_en = 1'b1, func_req = 1'b0, func_long = 1'b0;
    logic     pin_en = 1'b0, boot_hdr_last = 1'b0, hold_low = 1'b0;
    logic     rst_pin_in, rst_pin_out, rst_pin_oe, core_rst_n;
    logic     boot_assist_loader, normal_run_mode;
    rss_src_t seq_src;
    int       error_cnt = 0, n_compared = 0, oe_n, boot_n;

    always #5 core_clk = ~core_clk;

    rss_sequencer #(.DESTR_SELFTEST_CYC_P(DST), .DESTR_PLAIN_CYC_P(DPL),
        .EXT_LONG_CYC_P(EXL), .FUNC_LONG_CYC_P(FNL), .BOOT_FIRST_CYC_P(30),
        .BOOT_LAST_CYC_P(50)) i_rss_sequencer (
        .core_clk, .rst_n, .destr_req, .selftest_en, .func_req, .func_long,
        .functional_reset_pin_enable(pin_en), .boot_hdr_last, .rst_pin_in,
        .rst_pin_out, .rst_pin_oe, .core_rst_n, .boot_assist_loader,
        .normal_run_mode, .seq_src);
    rss_ext_gen i_rss_ext_gen (.rst_pin_out, .rst_pin_oe, .hold_low,
        .rst_pin_in);

    task automatic fail(input string m);
        error_cnt++;
        $display("ERROR %0t: %s", $time, m);
    endtask
    task automatic chk_num(input int got, input int exp, input string m);
        n_compared++;
        if (got != exp) fail(m);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_compared++;
        if (got !== exp) fail(m);
    endtask
    task automatic chk_src(input rss_src_t got, input rss_src_t exp);
        n_compared++;
        if (got !== exp) fail("wrong sequence cause");
    endtask
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Drops requests after plen cycles and counts pulled cycles until run.
    // The first few cycles are skipped because run mode falls a cycle late.
    task automatic wait_run(input int plen, output int n);
        int i;
        n = 0;
        boot_n = 0;
        for (i = 0; i < 3000; i++) begin
            @(negedge core_clk);
            if (rst_pin_oe === 1'b1) n++;
            if (boot_assist_loader === 1'b1) boot_n++;
            if (i == plen - 1) begin
                func_req = 1'b0;
                destr_req = 1'b0;
            end
            if (normal_run_mode === 1'b1 && i > 2) break;
        end
        if (i == 3000) begin
            fail("run mode never reached");
            report_and_stop();
        end
    endtask

    // Power-up runs the self-test destructive sequence.
    task automatic t_powerup;
        wait_run(1, oe_n);
        chk_src(seq_src, SRC_DESTR_SELFTEST);
        chk_bit(oe_n > DST, 1'b1, "power-up reset short");
        chk_bit(core_rst_n, 1'b1, "core still held");
        chk_num(boot_n, 30 + 1, "boot first length");
        chk_bit(rst_pin_out, 1'b0, "pin driven high");
        $display("test powerup done");
    endtask

    // Functional sequences pull the pin only when enabled.
    task automatic t_func(input logic lng, input logic en);
        func_req = 1'b1;
        func_long = lng;
        pin_en = en;
        wait_run(1, oe_n);
        chk_src(seq_src, lng ? SRC_FUNC_LONG : SRC_FUNC_SHORT);
        chk_num(oe_n, en ? (lng ? FNL : FUNC_SHORT_CYC) + 1 : 0, "pull");
        $display("test functional %0b%0b done", lng, en);
    endtask

    // A held destructive request restarts the full count.
    task automatic t_destr;
        selftest_en = 1'b0;
        boot_hdr_last = 1'b1;
        destr_req = 1'b1;
        wait_run(2, oe_n);
        chk_src(seq_src, SRC_DESTR_PLAIN);
        chk_num(oe_n, DPL + 2, "restart length");
        chk_num(boot_n, 50 + 1, "boot last length");
        $display("test destructive done");
    endtask

    // The generator holds the pin past the assert phase into phase three, then lets go.
    task automatic t_ext;
        int n;
        n = 0;
        hold_low = 1'b1;
        repeat (150) begin
            @(negedge core_clk);
            if (rst_pin_oe === 1'b1) n++;
        end
        chk_src(seq_src, SRC_EXT_LONG);
        chk_num(n, EXL + 1, "external length");
        chk_bit(core_rst_n, 1'b0, "hold not extended");
        hold_low = 1'b0;
        wait_run(1, oe_n);
        chk_bit(normal_run_mode, 1'b1, "no run after release");
        $display("test external done");
    endtask

    initial begin
        int k;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        t_powerup();
        for (k = 0; k < 4; k++) begin
            t_func(k[1], k[0]);
        end
        t_destr();
        t_ext();
        report_and_stop();
    end
endmodule
